/* File: test/nv_store_model.sv */
// Far side of the parser: the non-volatile store and the reply transmitter.
// Assumes the parser's clock and reset; the store acks once per write request.
`timescale 1ns/1ps
module nv_store_model #(
	parameter int ACK_DELAY = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Store
	input wire logic nv_write_i,
	output logic nv_ack_o,
	// Transmitter
	output logic tx_ready_o
);
	int cnt;

	// ----------------------------------------------------------------
	// Slow store ack, transmitter stalling every other cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			nv_ack_o <= 1'b0;
			tx_ready_o <= 1'b0;
		end else begin
			tx_ready_o <= ~tx_ready_o;
			nv_ack_o <= 1'b0;
			if (nv_write_i && !nv_ack_o && cnt == ACK_DELAY) begin
				nv_ack_o <= 1'b1;
				cnt <= 0;
			end else if (nv_write_i && !nv_ack_o) begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule : nv_store_model

/* File: test/testbench.sv */
// Self-checking bench for the command parser.
// Assumes the parser package and the store model are compiled first.
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, psel, pen, pwr, pready, pslverr, rxv, txv, txr, nvw, nva, rstrt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] rxd, txd;
	logic err;
	cmdp_pkg::nv_req_type nvreq;
	logic [33:0] nv_last;
	logic [7:0] rxq[$];
	int n_fail, check_count, nv_n, rs_n;

	cmd_parser #(.TIMEOUT_DEFAULT(50)) i_cmd_parser (.CLOCK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .RX_DATA_I(rxd), .RX_VALID_I(rxv), .TX_DATA_O(txd),
		.TX_VALID_O(txv), .TX_READY_I(txr), .NV_WRITE_O(nvw), .NV_REQ_O(nvreq), .NV_ACK_I(nva),
		.RESTART_O(rstrt));
	nv_store_model i_nv_store_model (.clk_i(clk), .rst_n_i(rst_n), .nv_write_i(nvw), .nv_ack_o(nva),
		.tx_ready_o(txr));

	// ----------------------------------------------------------------
	// Clock, monitors, shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		if (txv === 1'b1 && txr === 1'b1) rxq.push_back(txd);
		if (nvw === 1'b1 && nva === 1'b1) begin
			nv_n++;
			nv_last = nvreq;
		end
		if (rstrt === 1'b1) rs_n++;
	end

	task chk(input string w, input logic [33:0] e, input logic [33:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task cmd(input string s, input bit nv, input logic [33:0] nvx, input bit rs, input logic [3:0] code);
		int n0, r0;
		n0 = nv_n;
		r0 = rs_n;
		rxq.delete();
		foreach (s[i]) begin
			@(posedge clk);
			rxd <= s[i];
			rxv <= 1'b1;
			@(posedge clk);
			rxv <= 1'b0;
		end
		repeat (120) @(posedge clk);
		chk({s, " stores"}, n0 + nv, nv_n);
		if (nv) chk({s, " store"}, nvx, nv_last);
		chk({s, " restarts"}, r0 + rs, rs_n);
		if (code != 4'h0) begin
			chk({s, " reply"}, 3, rxq.size());
			if (rxq.size() == 3) chk({s, " reply"}, {10'h000, 8'h3F, 8'h30 + code, 8'h0D}, {rxq[0], rxq[1], rxq[2]});
		end else chk({s, " no reply"}, 0, rxq.size());
	endtask : cmd

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		apb(0, cmdp_pkg::REG_CTRL, 32'h0000_0000);
		chk("ctrl reset", 0, rd);
		apb(0, cmdp_pkg::REG_TIMEOUT, 32'h0000_0000);
		chk("timeout reset", 50, rd);
		apb(0, 12'h014, 32'h0000_0000);
		chk("unmapped", 1, {rd, err});
		cmd("XY\015", 0, 0, 0, 4'h0);
		apb(0, cmdp_pkg::REG_STATUS, 32'h0000_0000);
		chk("status code", 1, rd[3:0]);
		apb(1, cmdp_pkg::REG_CTRL, 32'h0000_0001);
		$display("registers done");
	endtask : t_regs

	task t_store;
		cmd("RA\015", 0, 0, 1, 4'h0);
		for (int k = 0; k <= 8; k++)
			cmd($sformatf("P1%0d\015", k), 1, {cmdp_pkg::NV_PRESET, 28'h000_0000, 4'(k)}, 1, 4'h0);
		cmd("P1F\015", 1, {cmdp_pkg::NV_PRESET, 32'h0000_000F}, 1, 4'h0);
		cmd("P00B30000\015", 1, {cmdp_pkg::NV_SERIAL, 32'h0000_0BC0}, 1, 4'h0);
		cmd("P00C01213\015", 1, {cmdp_pkg::NV_SERIAL, 32'h0000_0C37}, 1, 4'h0);
		apb(0, cmdp_pkg::REG_SERIAL, 32'h0000_0000);
		chk("serial reg", 32'h0000_0C37, rd[15:0]);
		cmd("P214585\015", 1, {cmdp_pkg::NV_CUSTOM, 32'h0001_4585}, 1, 4'h0);
		apb(0, cmdp_pkg::REG_CAN, 32'h0000_0000);
		chk("can reg", 32'h0014_585F, rd);
		$display("store commands done");
	endtask : t_store

	task t_errors;
		cmd("XY\015", 0, 0, 0, 4'h1);
		cmd("P1\015", 0, 0, 0, 4'h2);
		cmd("P0000000000000000\015", 0, 0, 0, 4'h2);
		cmd("\015", 0, 0, 0, 4'h1);
		cmd("P19\015", 0, 0, 0, 4'h1);
		cmd("P00130000\015", 0, 0, 0, 4'h1);
		cmd("P21458G\015", 0, 0, 0, 4'h1);
		cmd("XY\015\015", 0, 0, 0, 4'h1);
		apb(0, cmdp_pkg::REG_STATUS, 32'h0000_0000);
		chk("overrun status", 5'h14, rd[4:0]);
		apb(1, cmdp_pkg::REG_STATUS, 32'h0000_0000);
		apb(0, cmdp_pkg::REG_STATUS, 32'h0000_0000);
		chk("status cleared", 0, rd[4:0]);
		$display("error replies done");
	endtask : t_errors

	task t_chksum;
		apb(1, cmdp_pkg::REG_CTRL, 32'h0000_0005);
		cmd("RA93\015", 0, 0, 1, 4'h0);
		cmd("RA94\015", 0, 0, 0, 4'h3);
		cmd("P14B5\015", 1, {cmdp_pkg::NV_PRESET, 32'h0000_0004}, 1, 4'h0);
		apb(1, cmdp_pkg::REG_CTRL, 32'h0000_0001);
		cmd("RA", 0, 0, 0, 4'h5);
		$display("checksum and timeout done");
	endtask : t_chksum

	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{rst_n, psel, pen, pwr, rxv} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rxd = 8'h00;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_store();
		t_errors();
		t_chksum();
		final_report();
	end

	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule : testbench

/* File: verilog/cmd_parser.sv */
// ASCII configuration command parser with APB control registers.
// Assumes a byte receiver and transmitter on the same clock and a
// non-volatile store that acknowledges each write with one pulse.
//
// Function
// - Data digit 0..3 selects five to eight bits
// - Stop digit 0 one, 1 two stop bits
// - Parity digit 0 none, 1 odd, 2 even
// - Checksum digit 0 off, 1 on
// - Rate code 02..0C valid; 00, 01 reserved
// - Response digit bit1 timestamp, bit0 error replies
// - Valid serial setup: store, then restart
// - Error reply is question mark, code, CR
// - Preset CAN code 0..8 or F valid
// - Valid preset command: store, then restart
// - Custom rate is five hex characters
// - Valid custom command: store, then restart
// - Valid reboot command restarts the device
// - Error replies only when error response enabled
// - Unknown header reports code 1
// - Wrong data count reports code 2
// - Checksum mismatch is reported
// - Transmit overrun reports code 4
// - Missing terminator reports code 5
// - Carriage return ends every command
// - Checksum is low byte of character sum
`timescale 1ns/1ps
module cmd_parser #(
	parameter int TIMEOUT_DEFAULT = cmdp_pkg::TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	// Received characters
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	// Reply characters
	output logic [7:0] TX_DATA_O,
	output logic TX_VALID_O,
	input wire logic TX_READY_I,
	// Non-volatile store and restart
	output logic NV_WRITE_O,
	output cmdp_pkg::nv_req_type NV_REQ_O,
	input wire logic NV_ACK_I,
	output logic RESTART_O
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] buf_r [cmdp_pkg::BUF_DEPTH];
	logic [4:0] cnt_r;
	logic ovf_r;
	logic [7:0] sum_r;
	logic [31:0] timer_r;
	logic [31:0] timeout_r;
	logic [2:0] ctrl_r;
	logic [3:0] last_err_r;
	logic overrun_r;
	cmdp_pkg::serial_cfg_type serial_r;
	logic [3:0] preset_r;
	logic [19:0] custom_r;
	cmdp_pkg::act_type act_r;
	logic [1:0] tx_idx_r;
	logic [3:0] tx_code_r;
	logic restart_r;
	logic apb_wr;

	// ----------------------------------------------------------------
	// Hex decoders over the field and checksum positions
	// ----------------------------------------------------------------
	logic [7:0] dec_char [cmdp_pkg::N_DEC];
	logic [3:0] nib [cmdp_pkg::N_DEC];
	logic hv [cmdp_pkg::N_DEC];
	logic [4:0] last1;
	logic [4:0] last2;
	assign last1 = cnt_r - 5'h01;
	assign last2 = cnt_r - 5'h02;
	genvar g;
	generate
		for (g = 0; g < cmdp_pkg::N_DEC; g++) begin : g_dec
			if (g < 7) begin : g_fld
				assign dec_char[g] = buf_r[g + 2];
			end else if (g == 7) begin : g_hi
				assign dec_char[g] = buf_r[last2[3:0]];
			end else begin : g_lo
				assign dec_char[g] = buf_r[last1[3:0]];
			end
			hex_char_decode u_dec (
				.char_i(dec_char[g]),
				.nibble_o(nib[g]),
				.valid_o(hv[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Command evaluation at the terminator
	// ----------------------------------------------------------------
	logic cr_evt;
	logic tmo_evt;
	logic chk_en;
	logic [4:0] dlen;
	logic [7:0] body_sum;
	logic is_ser, is_pre, is_cus, is_ra, is_frame;
	logic [7:0] rate;
	logic [3:0] eval_err;
	logic [3:0] evt_err;
	logic err_evt;

	assign cr_evt = RX_VALID_I && RX_DATA_I == cmdp_pkg::CHAR_CR && act_r == cmdp_pkg::ACT_IDLE;
	assign tmo_evt = cnt_r != 5'h00 && timer_r >= timeout_r && !cr_evt;
	assign chk_en = ctrl_r[cmdp_pkg::CTRL_CHK_BIT];
	assign dlen = chk_en ? cnt_r - cmdp_pkg::LEN_CHK : cnt_r;
	assign body_sum = chk_en ? 8'(sum_r - buf_r[last1[3:0]] - buf_r[last2[3:0]]) : sum_r;
	assign is_ser = buf_r[0] == cmdp_pkg::CHAR_P && buf_r[1] == cmdp_pkg::CHAR_ZERO;
	assign is_pre = buf_r[0] == cmdp_pkg::CHAR_P && buf_r[1] == cmdp_pkg::CHAR_ONE;
	assign is_cus = buf_r[0] == cmdp_pkg::CHAR_P && buf_r[1] == cmdp_pkg::CHAR_TWO;
	assign is_ra = buf_r[0] == cmdp_pkg::CHAR_R && buf_r[1] == cmdp_pkg::CHAR_A;
	assign is_frame = buf_r[0] == cmdp_pkg::CHAR_SD || buf_r[0] == cmdp_pkg::CHAR_SR
		|| buf_r[0] == cmdp_pkg::CHAR_XD || buf_r[0] == cmdp_pkg::CHAR_XR || buf_r[0] == cmdp_pkg::CHAR_S;
	assign rate = {nib[0], nib[1]};

	always_comb begin
		eval_err = cmdp_pkg::ERR_NONE;
		if (cnt_r == 5'h00 || !(is_ser || is_pre || is_cus || is_ra || is_frame)) begin
			eval_err = cmdp_pkg::ERR_HEADER;
		end else if (ovf_r || (chk_en && cnt_r < 5'h03)) begin
			eval_err = cmdp_pkg::ERR_LENGTH;
		end else if ((is_ser && dlen != cmdp_pkg::LEN_SERIAL) || (is_pre && dlen != cmdp_pkg::LEN_PRESET)
			|| (is_cus && dlen != cmdp_pkg::LEN_CUSTOM) || (is_ra && dlen != cmdp_pkg::LEN_RESTART)) begin
			eval_err = cmdp_pkg::ERR_LENGTH;
		end else if (chk_en && !(hv[7] && hv[8] && {nib[7], nib[8]} == body_sum)) begin
			eval_err = cmdp_pkg::ERR_CHECKSUM;
		end else if (is_ser && !(hv[0] && hv[1] && hv[2] && hv[3] && hv[4] && hv[5] && hv[6]
			&& rate >= cmdp_pkg::RATE_MIN && rate <= cmdp_pkg::RATE_MAX
			&& nib[2] <= cmdp_pkg::DATA_MAX && nib[3] <= cmdp_pkg::STOP_MAX
			&& nib[4] <= cmdp_pkg::PAR_MAX && nib[5] <= cmdp_pkg::CHK_MAX
			&& nib[6] <= cmdp_pkg::RESP_MAX)) begin
			eval_err = cmdp_pkg::ERR_FIELD;
		end else if (is_pre && !(hv[0] && (nib[0] <= cmdp_pkg::PRESET_MAX || nib[0] == cmdp_pkg::PRESET_USER))) begin
			eval_err = cmdp_pkg::ERR_FIELD;
		end else if (is_cus && !(hv[0] && hv[1] && hv[2] && hv[3] && hv[4])) begin
			eval_err = cmdp_pkg::ERR_FIELD;
		end
	end

	assign err_evt = tmo_evt || (cr_evt && eval_err != cmdp_pkg::ERR_NONE);
	assign evt_err = tmo_evt ? cmdp_pkg::ERR_TIMEOUT : eval_err;

	// ----------------------------------------------------------------
	// Command buffer, running sum and inter-character timer
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cnt_r <= 5'h00;
			ovf_r <= 1'b0;
			sum_r <= 8'h00;
			timer_r <= 32'h0000_0000;
		end else if (cr_evt || tmo_evt) begin
			cnt_r <= 5'h00;
			ovf_r <= 1'b0;
			sum_r <= 8'h00;
			timer_r <= 32'h0000_0000;
		end else if (RX_VALID_I && act_r == cmdp_pkg::ACT_IDLE) begin
			timer_r <= 32'h0000_0000;
			sum_r <= 8'(sum_r + RX_DATA_I);
			if (cnt_r == 5'(cmdp_pkg::BUF_DEPTH)) begin
				ovf_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end else if (cnt_r != 5'h00) begin
			timer_r <= timer_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RX_VALID_I && act_r == cmdp_pkg::ACT_IDLE && !cr_evt && cnt_r < 5'(cmdp_pkg::BUF_DEPTH)) begin
			buf_r[cnt_r[3:0]] <= RX_DATA_I;
		end
	end

	// ----------------------------------------------------------------
	// Error reporting and reply transmitter
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			TX_VALID_O <= 1'b0;
			TX_DATA_O <= 8'h00;
			tx_idx_r <= 2'h0;
			tx_code_r <= 4'h0;
		end else if (TX_VALID_O) begin
			if (TX_READY_I) begin
				tx_idx_r <= tx_idx_r + 2'h1;
				TX_VALID_O <= tx_idx_r != 2'h2;
				TX_DATA_O <= tx_idx_r == 2'h0 ? 8'(cmdp_pkg::CHAR_ZERO + tx_code_r) : cmdp_pkg::CHAR_CR;
			end
		end else if (err_evt && ctrl_r[cmdp_pkg::CTRL_ERR_BIT]) begin
			TX_VALID_O <= 1'b1;
			TX_DATA_O <= cmdp_pkg::CHAR_Q;
			tx_idx_r <= 2'h0;
			tx_code_r <= evt_err;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			last_err_r <= cmdp_pkg::ERR_NONE;
			overrun_r <= 1'b0;
		end else if (err_evt && ctrl_r[cmdp_pkg::CTRL_ERR_BIT] && TX_VALID_O) begin
			last_err_r <= cmdp_pkg::ERR_OVERRUN;
			overrun_r <= 1'b1;
		end else if (err_evt) begin
			last_err_r <= evt_err;
		end else if (apb_wr && PADDR_I == cmdp_pkg::REG_STATUS) begin
			last_err_r <= cmdp_pkg::ERR_NONE;
			overrun_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Store and restart sequencer
	// ----------------------------------------------------------------
	logic cmd_ok;
	assign cmd_ok = cr_evt && eval_err == cmdp_pkg::ERR_NONE;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			act_r <= cmdp_pkg::ACT_IDLE;
			NV_WRITE_O <= 1'b0;
			NV_REQ_O <= '0;
			restart_r <= 1'b0;
		end else begin
			restart_r <= act_r == cmdp_pkg::ACT_RESTART;
			unique case (act_r)
				cmdp_pkg::ACT_IDLE: begin
					if (cmd_ok && is_ra) begin
						act_r <= cmdp_pkg::ACT_RESTART;
					end else if (cmd_ok && (is_ser || is_pre || is_cus)) begin
						act_r <= cmdp_pkg::ACT_STORE;
						NV_WRITE_O <= 1'b1;
						if (is_ser) begin
							NV_REQ_O.sel <= cmdp_pkg::NV_SERIAL;
							NV_REQ_O.data <= {16'h0000, rate, nib[2][1:0], nib[3][0], nib[4][1:0], nib[5][0], nib[6][1:0]};
						end else if (is_pre) begin
							NV_REQ_O.sel <= cmdp_pkg::NV_PRESET;
							NV_REQ_O.data <= {28'h000_0000, nib[0]};
						end else begin
							NV_REQ_O.sel <= cmdp_pkg::NV_CUSTOM;
							NV_REQ_O.data <= {12'h000, nib[0], nib[1], nib[2], nib[3], nib[4]};
						end
					end
				end
				cmdp_pkg::ACT_STORE: begin
					if (NV_ACK_I) begin
						NV_WRITE_O <= 1'b0;
						act_r <= cmdp_pkg::ACT_RESTART;
					end
				end
				cmdp_pkg::ACT_RESTART: begin
					act_r <= cmdp_pkg::ACT_IDLE;
				end
				default: begin
					act_r <= cmdp_pkg::ACT_IDLE;
				end
			endcase
		end
	end
	assign RESTART_O = restart_r;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			serial_r <= '0;
			preset_r <= 4'h0;
			custom_r <= 20'h0_0000;
		end else if (act_r == cmdp_pkg::ACT_STORE && NV_ACK_I) begin
			unique case (NV_REQ_O.sel)
				cmdp_pkg::NV_SERIAL: serial_r <= NV_REQ_O.data[15:0];
				cmdp_pkg::NV_PRESET: preset_r <= NV_REQ_O.data[3:0];
				cmdp_pkg::NV_CUSTOM: custom_r <= NV_REQ_O.data[19:0];
				default: preset_r <= preset_r;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// APB slave, answer one cycle into the access phase
	// ----------------------------------------------------------------
	logic hit;
	logic [31:0] rd_val;
	assign apb_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (PADDR_I)
			cmdp_pkg::REG_CTRL: rd_val = {29'h0000_0000, ctrl_r};
			cmdp_pkg::REG_TIMEOUT: rd_val = timeout_r;
			cmdp_pkg::REG_STATUS: begin
				rd_val[3:0] = last_err_r;
				rd_val[cmdp_pkg::STAT_OVR_BIT] = overrun_r;
				rd_val[cmdp_pkg::STAT_BUSY_BIT] = cnt_r != 5'h00 || act_r != cmdp_pkg::ACT_IDLE;
			end
			cmdp_pkg::REG_SERIAL: rd_val = {16'h0000, serial_r};
			cmdp_pkg::REG_CAN: rd_val = {8'h00, custom_r, preset_r};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
			PREADY_O <= 1'b1;
			PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_val;
			PSLVERR_O <= !hit;
		end else begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ctrl_r <= cmdp_pkg::CTRL_RESET;
			timeout_r <= 32'(TIMEOUT_DEFAULT);
		end else if (apb_wr && PADDR_I == cmdp_pkg::REG_CTRL) begin
			ctrl_r <= PWDATA_I[2:0];
		end else if (apb_wr && PADDR_I == cmdp_pkg::REG_TIMEOUT) begin
			timeout_r <= PWDATA_I;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	sequence s_reply_start;
		!TX_VALID_O ##1 TX_VALID_O && TX_DATA_O == cmdp_pkg::CHAR_Q;
	endsequence
	sequence s_store_ack;
		act_r == cmdp_pkg::ACT_STORE && NV_ACK_I;
	endsequence

	a_reply_prefix: assert property ($rose(TX_VALID_O) |-> TX_DATA_O == cmdp_pkg::CHAR_Q)
		else $error("reply does not open with question mark");
	a_reply_gate: assert property (s_reply_start |-> $past(ctrl_r[cmdp_pkg::CTRL_ERR_BIT]))
		else $error("reply sent while error replies disabled");
	a_reply_tail: assert property (TX_VALID_O && TX_READY_I && tx_idx_r == 2'h1 |=> TX_DATA_O == cmdp_pkg::CHAR_CR)
		else $error("reply not closed by carriage return");
	a_store_restart: assert property (s_store_ack |-> ##2 RESTART_O && !NV_WRITE_O)
		else $error("no restart after store acknowledge");
	a_reboot_cmd: assert property (cmd_ok && is_ra |-> ##2 RESTART_O)
		else $error("reboot command did not restart");
	a_header_code: assert property (cr_evt && cnt_r == 5'h00 && !TX_VALID_O |=> last_err_r == cmdp_pkg::ERR_HEADER)
		else $error("bare terminator not a header error");
	a_timeout_drop: assert property (tmo_evt && !TX_VALID_O |=> last_err_r == cmdp_pkg::ERR_TIMEOUT && cnt_r == 5'h00)
		else $error("timeout did not discard command");
	a_overrun_code: assert property (err_evt && TX_VALID_O && ctrl_r[cmdp_pkg::CTRL_ERR_BIT]
		|=> last_err_r == cmdp_pkg::ERR_OVERRUN && overrun_r)
		else $error("overrun not reported");
	a_serial_rate: assert property ($rose(NV_WRITE_O) && NV_REQ_O.sel == cmdp_pkg::NV_SERIAL
		|-> NV_REQ_O.data[15:8] >= cmdp_pkg::RATE_MIN && NV_REQ_O.data[15:8] <= cmdp_pkg::RATE_MAX)
		else $error("reserved serial rate stored");
	a_preset_code: assert property ($rose(NV_WRITE_O) && NV_REQ_O.sel == cmdp_pkg::NV_PRESET
		|-> NV_REQ_O.data[3:0] <= cmdp_pkg::PRESET_MAX || NV_REQ_O.data[3:0] == cmdp_pkg::PRESET_USER)
		else $error("reserved preset code stored");
	a_bad_no_store: assert property (cr_evt && eval_err != cmdp_pkg::ERR_NONE |=> act_r == cmdp_pkg::ACT_IDLE)
		else $error("invalid command started an action");

endmodule : cmd_parser

/* File: verilog/cmdp_pkg.sv */
// Constants and types shared by the ASCII configuration command parser.
// Assumes one 250 MHz clock; the testbench reads it as well as the parser.
package cmdp_pkg;

	// ----------------------------------------------------------------
	// Characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_Q = 8'h3F;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_ONE = 8'h31;
	localparam logic [7:0] CHAR_TWO = 8'h32;
	localparam logic [7:0] CHAR_P = 8'h50;
	localparam logic [7:0] CHAR_R = 8'h52;
	localparam logic [7:0] CHAR_A = 8'h41;
	localparam logic [7:0] CHAR_SD = 8'h74;
	localparam logic [7:0] CHAR_SR = 8'h54;
	localparam logic [7:0] CHAR_XD = 8'h65;
	localparam logic [7:0] CHAR_XR = 8'h45;
	localparam logic [7:0] CHAR_S = 8'h53;

	// ----------------------------------------------------------------
	// Error codes and command lengths
	// ----------------------------------------------------------------
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_HEADER = 4'h1;
	localparam logic [3:0] ERR_LENGTH = 4'h2;
	localparam logic [3:0] ERR_CHECKSUM = 4'h3;
	localparam logic [3:0] ERR_OVERRUN = 4'h4;
	localparam logic [3:0] ERR_TIMEOUT = 4'h5;
	localparam logic [3:0] ERR_FIELD = 4'h1;
	localparam int BUF_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] LEN_SERIAL = 5'h09;
	localparam logic [4:0] LEN_PRESET = 5'h03;
	localparam logic [4:0] LEN_CUSTOM = 5'h07;
	localparam logic [4:0] LEN_RESTART = 5'h02;
	localparam logic [4:0] LEN_CHK = 5'h02;
	localparam int N_DEC = 9;

	// ----------------------------------------------------------------
	// Field limits
	// ----------------------------------------------------------------
	localparam logic [7:0] RATE_MIN = 8'h02;
	localparam logic [7:0] RATE_MAX = 8'h0C;
	localparam logic [3:0] DATA_MAX = 4'h3;
	localparam logic [3:0] STOP_MAX = 4'h1;
	localparam logic [3:0] PAR_MAX = 4'h2;
	localparam logic [3:0] CHK_MAX = 4'h1;
	localparam logic [3:0] RESP_MAX = 4'h3;
	localparam logic [3:0] PRESET_MAX = 4'h8;
	localparam logic [3:0] PRESET_USER = 4'hF;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_TIMEOUT = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_SERIAL = 12'h00C;
	localparam logic [11:0] REG_CAN = 12'h010;
	localparam int CTRL_ERR_BIT = 0;
	localparam int CTRL_TS_BIT = 1;
	localparam int CTRL_CHK_BIT = 2;
	localparam int STAT_OVR_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int TIMEOUT_US = 1000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {NV_NONE, NV_SERIAL, NV_PRESET, NV_CUSTOM} nv_sel_type;
	typedef enum logic [1:0] {ACT_IDLE, ACT_STORE, ACT_RESTART} act_type;
	typedef struct packed {
		logic [7:0] rate;
		logic [1:0] data_bits;
		logic stop;
		logic [1:0] parity;
		logic chk;
		logic [1:0] resp;
	} serial_cfg_type;
	typedef struct packed {
		nv_sel_type sel;
		logic [31:0] data;
	} nv_req_type;

endpackage : cmdp_pkg

/* File: verilog/hex_char_decode.sv */
// Decodes one ASCII hexadecimal character into its nibble.
// Assumes a plain byte input; purely combinational.
`timescale 1ns/1ps
module hex_char_decode (
	// Character in
	input wire logic [7:0] char_i,
	// Nibble out
	output logic [3:0] nibble_o,
	output logic valid_o
);
	always_comb begin
		valid_o = 1'b1;
		nibble_o = 4'h0;
		if (char_i >= 8'h30 && char_i <= 8'h39) begin
			nibble_o = 4'(char_i - 8'h30);
		end else if (char_i >= 8'h41 && char_i <= 8'h46) begin
			nibble_o = 4'(char_i - 8'h37);
		end else if (char_i >= 8'h61 && char_i <= 8'h66) begin
			nibble_o = 4'(char_i - 8'h57);
		end else begin
			valid_o = 1'b0;
		end
	end
endmodule : hex_char_decode
